// ---- lbis_device.sv ----
// bridge end of the local bus: slave decode, bus ownership, dma handshake
// assumes all local bus inputs are synchronous to mclk_i
// Overview of operation
// R1: two chip selects: registers versus pci window
// R2: image select low picks image 0, else 1
// R3: take bus only after busy/grant-ack negate
// R4: unaligned burst start inserts wait states
// R5: dma: drive request, ack per address mode
// R6: address never decoded during dma transfers
// R7: end-of-transfer input ignored during dma
// R8: dual-address dma always ends with acknowledge
// R9: sample and drive only on rising clock
module lbis_device
  import lbis_pkg::*;
#(
  parameter logic [3:0] UNALIGN_WAITS = LBIS_UNALIGN_WAITS
) (
  // clock, reset, enable
  input  wire logic          mclk_i,
  input  wire logic          sys_rst_i,
  input  wire logic          clk_en_i,
  // local bus
  lbis_if.device             bus,
  // user side: slave accesses
  output lbis_acc_type       acc_kind_o,
  output logic               acc_valid_o,
  output logic [31:0]        acc_addr_o,
  output logic [31:0]        acc_wdata_o,
  output logic               acc_write_o,
  input  wire logic [31:0]   acc_rdata_i,
  // user side: mastership and dma
  input  wire logic          own_req_i,
  output logic               own_granted_o,
  input  wire logic          dma_want_i,
  output logic               dma_beat_o,
  output logic               dma_error_o,
  output logic               dma_retry_o,
  output logic [LBIS_TC_W-1:0] dma_code_o
);
  typedef enum logic [2:0] {S_IDLE, S_WAIT, S_ACK, S_DMA} lbis_slv_type;
  typedef enum logic [1:0] {A_IDLE, A_REQ, A_WAITFREE, A_OWN} lbis_arb_type;

  lbis_slv_type  st_reg, st_next;
  lbis_arb_type  arb_reg, arb_next;
  logic [3:0]    wait_reg, wait_next;
  lbis_acc_type  kind_reg, kind_next;
  logic          valid_reg, valid_next;
  logic [31:0]   addr_reg, addr_next, wd_reg, wd_next, rd_reg, rd_next;
  logic          wr_reg, wr_next, ta_reg, ta_next, dma_request_n_reg, dma_request_n_next;
  logic          breq_reg, breq_next, bb_reg, bb_next, own_reg, own_next;
  logic          beat_reg, beat_next, err_reg, err_next, rty_reg, rty_next;
  logic [LBIS_TC_W-1:0] code_reg, code_next;
  logic          dma_cycle;

  ////////////////////////////////////////////////////////////////////////////
  // slave decode and dma handshake
  // dma cycle is marked by acknowledge, not by address [R6]
  assign dma_cycle = ~bus.dma_acknowledge_n & ~bus.transfer_start_n;

  always_comb begin
    st_next    = st_reg;
    wait_next  = wait_reg;
    kind_next  = kind_reg;
    valid_next = 1'b0;
    addr_next  = addr_reg;
    wd_next    = wd_reg;
    wr_next    = wr_reg;
    rd_next    = rd_reg;
    ta_next    = LBIS_NEG;
    beat_next  = 1'b0;
    err_next   = 1'b0;
    rty_next   = 1'b0;
    code_next  = code_reg;
    dma_request_n_next  = ~dma_want_i; // request line driven by device [R5]
    // end_of_transfer_n is never read, so it cannot alter dma [R7]
    case (st_reg)
      S_IDLE: begin
        if (dma_cycle) begin
          st_next = S_DMA; // address bus left unexamined [R6]
          if (bus.dual_address) begin
            code_next = bus.transfer_code; // code only in dual mode [R5]
            ta_next   = 1'b0; // normal ack, never retry or error [R8]
            beat_next = 1'b1;
          end
        end else if (!bus.transfer_start_n && (!bus.register_select_n ||
                     !bus.pci_window_select_n)) begin
          // register select wins over window select [R1]
          if (!bus.register_select_n)
            kind_next = LBIS_ACC_REG;
          else if (bus.image_select == LBIS_IMAGE0)
            kind_next = LBIS_ACC_IMG0; // [R2]
          else
            kind_next = LBIS_ACC_IMG1; // [R2]
          addr_next  = bus.addr;
          wd_next    = bus.wdata;
          wr_next    = ~bus.rd_wr_n;
          valid_next = 1'b1;
          // unaligned burst start costs wait states [R4]
          if (bus.burst && (bus.addr[LBIS_ALIGN_BITS-1:0] != '0)) begin
            wait_next = UNALIGN_WAITS;
            st_next   = S_WAIT;
          end else begin
            st_next = S_ACK;
          end
        end
      end
      S_WAIT: begin
        wait_next = wait_reg - 4'h1;
        if (wait_reg <= 4'h1)
          st_next = S_ACK;
      end
      S_ACK: begin
        // one cycle of latency so user read data is registered first
        rd_next = acc_rdata_i;
        ta_next = 1'b0;
        if (!bus.burst || bus.transfer_start_n)
          st_next = S_IDLE;
      end
      S_DMA: begin
        if (bus.dual_address) begin
          st_next = S_IDLE;
        end else begin
          // single mode: the memory side terminates, device samples [R5]
          if (!bus.host_ta_n || !bus.transfer_error_ack_n || !bus.transfer_retry_n) begin
            beat_next = ~bus.host_ta_n;
            err_next  = ~bus.transfer_error_ack_n;
            rty_next  = ~bus.transfer_retry_n;
            st_next   = S_IDLE;
          end
        end
      end
      default: st_next = S_IDLE;
    endcase
  end

  // all sampling and driving on the rising clock edge [R9]
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st_reg    <= S_IDLE;
      wait_reg  <= 4'h0;
      kind_reg  <= LBIS_ACC_NONE;
      valid_reg <= 1'b0;
      addr_reg  <= 32'h0;
      wd_reg    <= 32'h0;
      wr_reg    <= 1'b0;
      rd_reg    <= 32'h0;
      ta_reg    <= LBIS_NEG;
      dma_request_n_reg  <= LBIS_NEG;
      beat_reg  <= 1'b0;
      err_reg   <= 1'b0;
      rty_reg   <= 1'b0;
      code_reg  <= '0;
    end else if (clk_en_i) begin
      st_reg    <= st_next;
      wait_reg  <= wait_next;
      kind_reg  <= kind_next;
      valid_reg <= valid_next;
      addr_reg  <= addr_next;
      wd_reg    <= wd_next;
      wr_reg    <= wr_next;
      rd_reg    <= rd_next;
      ta_reg    <= ta_next;
      dma_request_n_reg  <= dma_request_n_next;
      beat_reg  <= beat_next;
      err_reg   <= err_next;
      rty_reg   <= rty_next;
      code_reg  <= code_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus ownership hand-over
  always_comb begin
    arb_next  = arb_reg;
    breq_next = breq_reg;
    bb_next   = bb_reg;
    own_next  = own_reg;
    case (arb_reg)
      A_IDLE: if (own_req_i) begin
        breq_next = 1'b0;
        arb_next  = A_REQ;
      end
      A_REQ: if (!bus.bus_grant_n)
        arb_next = A_WAITFREE;
      A_WAITFREE: begin
        // wait for the current owner to release both signals [R3]
        if (bus.host_bb_n && bus.bus_grant_ack_n) begin
          bb_next   = 1'b0;
          own_next  = 1'b1;
          breq_next = LBIS_NEG;
          arb_next  = A_OWN;
        end
      end
      A_OWN: if (!own_req_i) begin
        bb_next  = LBIS_NEG;
        own_next = 1'b0;
        arb_next = A_IDLE;
      end
      default: arb_next = A_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      arb_reg  <= A_IDLE;
      breq_reg <= LBIS_NEG;
      bb_reg   <= LBIS_NEG;
      own_reg  <= 1'b0;
    end else if (clk_en_i) begin
      arb_reg  <= arb_next;
      breq_reg <= breq_next;
      bb_reg   <= bb_next;
      own_reg  <= own_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops
  assign bus.dma_request_n = dma_request_n_reg;
  assign bus.dev_ta_n      = ta_reg;
  assign bus.rdata         = rd_reg;
  assign bus.bus_request_n = breq_reg;
  assign bus.dev_bb_n      = bb_reg;
  assign acc_kind_o        = kind_reg;
  assign acc_valid_o       = valid_reg;
  assign acc_addr_o        = addr_reg;
  assign acc_wdata_o       = wd_reg;
  assign acc_write_o       = wr_reg;
  assign own_granted_o     = own_reg;
  assign dma_beat_o        = beat_reg;
  assign dma_error_o       = err_reg;
  assign dma_retry_o       = rty_reg;
  assign dma_code_o        = code_reg;
endmodule

// ---- lbis_pkg.sv ----
// package for the local bus slave port with processor dma handshake
// assumes one local bus clock shared by both ends
package lbis_pkg;
  // image select values
  localparam logic        LBIS_IMAGE0        = 1'b0;
  localparam logic        LBIS_IMAGE1        = 1'b1;
  // burst alignment: low address bits that must be zero (16-byte)
  localparam int          LBIS_ALIGN_BITS    = 4;
  // wait states inserted for an unaligned burst start
  localparam logic [3:0]  LBIS_UNALIGN_WAITS = 4'h1;
  // transfer code width
  localparam int          LBIS_TC_W          = 4;
  // reset values of active-low outputs
  localparam logic        LBIS_NEG           = 1'b1;
  // access kinds seen by the user side of the device
  typedef enum logic [1:0] {
    LBIS_ACC_NONE, LBIS_ACC_REG, LBIS_ACC_IMG0, LBIS_ACC_IMG1
  } lbis_acc_type;
endpackage

// ---- lbis_if.sv ----
// interface joining the bridge end and the processor end of the local bus
// assumes the bench supplies mclk_i; every signal is a plain driven wire
interface lbis_if (
  input wire logic mclk_i
);
  import lbis_pkg::*;
  // access controls, driven by the processor
  logic                 register_select_n;
  logic                 pci_window_select_n;
  logic                 image_select;
  logic                 transfer_start_n;
  logic                 burst;
  logic                 rd_wr_n;
  logic [31:0]          addr;
  logic [31:0]          wdata;
  logic                 end_of_transfer_n;
  // dma handshake
  logic                 dma_request_n;
  logic                 dma_acknowledge_n;
  logic                 dual_address;
  logic [LBIS_TC_W-1:0] transfer_code;
  // termination: device drives ta in normal and dual dma, host in single dma
  logic                 dev_ta_n;
  logic                 host_ta_n;
  logic                 transfer_error_ack_n;
  logic                 transfer_retry_n;
  logic [31:0]          rdata;
  // arbitration
  logic                 bus_request_n;
  logic                 bus_grant_n;
  logic                 dev_bb_n;
  logic                 host_bb_n;
  logic                 bus_grant_ack_n;
  // wired-and of the two busy drivers and the two ack drivers
  wire bus_busy_n             = dev_bb_n & host_bb_n;
  wire transfer_acknowledge_n = dev_ta_n & host_ta_n;

  modport device (
    input  register_select_n, pci_window_select_n, image_select, transfer_start_n,
    input  burst, rd_wr_n, addr, wdata, end_of_transfer_n, dma_acknowledge_n,
    input  dual_address, transfer_code, host_ta_n, transfer_error_ack_n,
    input  transfer_retry_n, bus_grant_n, host_bb_n, bus_grant_ack_n, bus_busy_n,
    output dma_request_n, dev_ta_n, rdata, bus_request_n, dev_bb_n
  );
  modport host (
    output register_select_n, pci_window_select_n, image_select, transfer_start_n,
    output burst, rd_wr_n, addr, wdata, end_of_transfer_n, dma_acknowledge_n,
    output dual_address, transfer_code, host_ta_n, transfer_error_ack_n,
    output transfer_retry_n, bus_grant_n, host_bb_n, bus_grant_ack_n,
    input  dma_request_n, dev_ta_n, rdata, bus_request_n, dev_bb_n, bus_busy_n
  );
endinterface

// ---- lbis_host.sv ----
// processor end of the local bus: issues accesses, dma beats, arbitration
// assumes the bridge end shares mclk_i and honours the same handshakes
module lbis_host
  import lbis_pkg::*;
(
  // clock, reset, enable
  input  wire logic          mclk_i,
  input  wire logic          sys_rst_i,
  input  wire logic          clk_en_i,
  // local bus
  lbis_if.host               bus,
  // user side: access request
  input  wire logic          go_i,
  input  wire logic          go_reg_i,
  input  wire logic          go_image_i,
  input  wire logic          go_burst_i,
  input  wire logic          go_write_i,
  input  wire logic [31:0]   go_addr_i,
  input  wire logic [31:0]   go_wdata_i,
  output logic               done_o,
  output logic [31:0]        rdata_o,
  // user side: dma and ownership
  input  wire logic          dma_dual_i,
  input  wire logic [LBIS_TC_W-1:0] dma_code_i,
  input  wire logic          mem_ack_i,
  input  wire logic          own_bus_i,
  output logic               dma_pending_o
);
  typedef enum logic [1:0] {H_IDLE, H_ACC, H_DMA} lbis_hst_type;
  lbis_hst_type st_reg, st_next;
  logic         cs_reg_n_reg, cs_reg_n_next, cs_win_n_reg, cs_win_n_next;
  logic         img_reg, img_next, ts_reg, ts_next, bst_reg, bst_next, rw_reg, rw_next;
  logic [31:0]  a_reg, a_next, wd_reg, wd_next, rd_reg, rd_next;
  logic         dack_reg, dack_next, dual_reg, dual_next, ta_reg, ta_next;
  logic         done_reg, done_next, bb_reg, bb_next, bus_grant_ack_n_reg, bus_grant_ack_n_next, bg_reg, bg_next;
  logic [LBIS_TC_W-1:0] tc_reg, tc_next;

  ////////////////////////////////////////////////////////////////////////////
  // access and dma sequencing
  always_comb begin
    st_next = st_reg; cs_reg_n_next = LBIS_NEG; cs_win_n_next = LBIS_NEG;
    img_next = img_reg; ts_next = LBIS_NEG; bst_next = bst_reg; rw_next = rw_reg;
    a_next = a_reg; wd_next = wd_reg; rd_next = rd_reg; dack_next = LBIS_NEG;
    dual_next = dual_reg; ta_next = LBIS_NEG; done_next = 1'b0; tc_next = tc_reg;
    case (st_reg)
      H_IDLE: begin
        if (!bus.dma_request_n && bus.bus_request_n) begin
          // dma beat: window select negated single, asserted dual [R6]
          st_next = H_DMA; ts_next = 1'b0; dack_next = 1'b0;
          dual_next = dma_dual_i; tc_next = dma_code_i;
          cs_win_n_next = ~dma_dual_i;
        end else if (go_i) begin
          st_next = H_ACC; ts_next = 1'b0;
          cs_reg_n_next = ~go_reg_i; cs_win_n_next = go_reg_i; // [R1]
          img_next = go_image_i; bst_next = go_burst_i; rw_next = ~go_write_i;
          a_next = go_addr_i; wd_next = go_wdata_i;
        end
      end
      H_ACC: begin
        cs_reg_n_next = cs_reg_n_reg; cs_win_n_next = cs_win_n_reg;
        if (!bus.dev_ta_n) begin
          rd_next = bus.rdata; done_next = 1'b1; st_next = H_IDLE;
          cs_reg_n_next = LBIS_NEG; cs_win_n_next = LBIS_NEG;
        end
      end
      H_DMA: begin
        dack_next = 1'b0; cs_win_n_next = cs_win_n_reg;
        if (dual_reg) begin
          if (!bus.dev_ta_n) begin
            done_next = 1'b1; st_next = H_IDLE; dack_next = LBIS_NEG;
            cs_win_n_next = LBIS_NEG;
          end
        end else if (mem_ack_i) begin
          // single mode: memory side acknowledges the beat [R5]
          ta_next = 1'b0; done_next = 1'b1; st_next = H_IDLE;
          dack_next = LBIS_NEG; cs_win_n_next = LBIS_NEG;
        end
      end
      default: st_next = H_IDLE;
    endcase
  end

  // grant on request; busy/grant-ack drop when own use ends or once the bridge holds the bus, and are
  // never raised while the bridge holds it, yet both ends can take the bus on the same edge for one cycle [R3]
  always_comb begin
    bb_next = ~(own_bus_i & bus.dev_bb_n);
    bus_grant_ack_n_next = ~(own_bus_i & bus.dev_bb_n);
    bg_next = bus.bus_request_n;
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st_reg <= H_IDLE; cs_reg_n_reg <= LBIS_NEG; cs_win_n_reg <= LBIS_NEG;
      img_reg <= LBIS_IMAGE0; ts_reg <= LBIS_NEG; bst_reg <= 1'b0; rw_reg <= 1'b1;
      a_reg <= 32'h0; wd_reg <= 32'h0; rd_reg <= 32'h0; dack_reg <= LBIS_NEG;
      dual_reg <= 1'b0; ta_reg <= LBIS_NEG; done_reg <= 1'b0; tc_reg <= '0;
      bb_reg <= LBIS_NEG; bus_grant_ack_n_reg <= LBIS_NEG; bg_reg <= LBIS_NEG;
    end else if (clk_en_i) begin
      st_reg <= st_next; cs_reg_n_reg <= cs_reg_n_next; cs_win_n_reg <= cs_win_n_next;
      img_reg <= img_next; ts_reg <= ts_next; bst_reg <= bst_next; rw_reg <= rw_next;
      a_reg <= a_next; wd_reg <= wd_next; rd_reg <= rd_next; dack_reg <= dack_next;
      dual_reg <= dual_next; ta_reg <= ta_next; done_reg <= done_next; tc_reg <= tc_next;
      bb_reg <= bb_next; bus_grant_ack_n_reg <= bus_grant_ack_n_next; bg_reg <= bg_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs from flip-flops; error and retry never raised by this model
  assign bus.register_select_n    = cs_reg_n_reg;
  assign bus.pci_window_select_n  = cs_win_n_reg;
  assign bus.image_select         = img_reg;
  assign bus.transfer_start_n     = ts_reg;
  assign bus.burst                = bst_reg;
  assign bus.rd_wr_n              = rw_reg;
  assign bus.addr                 = a_reg;
  assign bus.wdata                = wd_reg;
  assign bus.end_of_transfer_n    = dack_reg; // pulsed with each dma beat [R7]
  assign bus.dma_acknowledge_n    = dack_reg;
  assign bus.dual_address         = dual_reg;
  assign bus.transfer_code        = tc_reg;
  assign bus.host_ta_n            = ta_reg;
  assign bus.transfer_error_ack_n = LBIS_NEG;
  assign bus.transfer_retry_n     = LBIS_NEG;
  assign bus.bus_grant_n          = bg_reg;
  assign bus.host_bb_n            = bb_reg;
  assign bus.bus_grant_ack_n      = bus_grant_ack_n_reg;
  assign done_o                   = done_reg;
  assign rdata_o                  = rd_reg;
  assign dma_pending_o            = ~bus.dma_request_n;
endmodule

// ---- lbis_properties.sv ----
// checker for the local bus between the bridge end and the processor end
// assumes signals of one lbis_if, default unaligned wait of one cycle
module lbis_properties (
  input wire logic        mclk_i,
  input wire logic        sys_rst_i,
  input wire logic        register_select_n,
  input wire logic        pci_window_select_n,
  input wire logic        transfer_start_n,
  input wire logic        burst,
  input wire logic [31:0] addr,
  input wire logic        dma_request_n,
  input wire logic        dma_acknowledge_n,
  input wire logic        dual_address,
  input wire logic        dev_ta_n,
  input wire logic        bus_request_n,
  input wire logic        bus_grant_n,
  input wire logic        dev_bb_n,
  input wire logic        host_bb_n,
  input wire logic        bus_grant_ack_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  ////////////////////////////////////////////////////////////////////////
  // slave accesses: select decode and wait states
  reg_access_a: assert property ($fell(transfer_start_n) && !register_select_n && !burst
    && dma_acknowledge_n |-> dev_ta_n ##2 !dev_ta_n) else $error("register access ack late");
  aligned_burst_a: assert property ($fell(transfer_start_n) && register_select_n && burst
    && !pci_window_select_n && dma_acknowledge_n && addr[3:0] == 4'h0
    |-> dev_ta_n ##2 !dev_ta_n) else $error("aligned burst ack wrong");
  unaligned_wait_a: assert property ($fell(transfer_start_n) && register_select_n && burst
    && !pci_window_select_n && dma_acknowledge_n && addr[3:0] != 4'h0
    |-> dev_ta_n[*3] ##1 !dev_ta_n) else $error("unaligned burst wait missing");
  single_ta_a: assert property (!dev_ta_n && !burst |=> dev_ta_n)
    else $error("single beat ack held");
  ////////////////////////////////////////////////////////////////////////
  // dma termination: device acks only in dual mode, next cycle
  dual_ack_a: assert property ($fell(transfer_start_n) && !dma_acknowledge_n && dual_address
    |=> !dev_ta_n) else $error("dual dma not acknowledged");
  single_quiet_a: assert property (!dma_acknowledge_n && !dual_address |-> dev_ta_n)
    else $error("device acked single dma");
  ////////////////////////////////////////////////////////////////////////
  // ownership hand-over
  take_bus_a: assert property ($fell(dev_bb_n) |-> $past(host_bb_n)
    && $past(bus_grant_ack_n) && !$past(bus_grant_n)) else $error("bus taken while busy");
  take_req_a: assert property ($fell(dev_bb_n) |-> !$past(bus_request_n))
    else $error("bus taken without request");
  // reset leaves every active-low output negated
  reset_idle_a: assert property (disable iff (1'b0) sys_rst_i |=> dev_ta_n && dev_bb_n
    && dma_request_n && bus_request_n) else $error("outputs active after reset");
endmodule

// ---- lbis_bench.sv ----
// self-checking bench: both ends joined by lbis_if, user sides driven here
// assumes the default wait-state parameter; inputs change on falling edges
module lbis_bench;
  import lbis_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic reg_s; logic img; logic bst; logic wr;
    logic [31:0] adr; logic [31:0] dat; lbis_acc_type kind;
  } lbis_row_type;
  logic mclk_i, sys_rst_i, clk_en_i, own_req_i, dma_want_i, go_i, go_reg_i, go_image_i;
  logic go_burst_i, go_write_i, dma_dual_i, mem_ack_i, own_bus_i;
  logic [31:0] acc_rdata_i, go_addr_i, go_wdata_i, acc_addr_o, acc_wdata_o, rdata_o;
  logic [3:0] dma_code_i, dma_code_o;
  logic acc_valid_o, acc_write_o, own_granted_o, dma_beat_o, dma_error_o, dma_retry_o;
  logic done_o, dma_pending_o;
  lbis_acc_type acc_kind_o, seen_kind;
  logic [31:0] seen_addr, seen_dat;
  logic seen_wr;
  int errors, num_checks, n;
  lbis_row_type rows [5];
  lbis_if i_lbis_if (.mclk_i(mclk_i));
  lbis_device i_lbis_device (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
    .bus(i_lbis_if.device), .acc_kind_o(acc_kind_o), .acc_valid_o(acc_valid_o),
    .acc_addr_o(acc_addr_o), .acc_wdata_o(acc_wdata_o), .acc_write_o(acc_write_o),
    .acc_rdata_i(acc_rdata_i), .own_req_i(own_req_i), .own_granted_o(own_granted_o),
    .dma_want_i(dma_want_i), .dma_beat_o(dma_beat_o), .dma_error_o(dma_error_o),
    .dma_retry_o(dma_retry_o), .dma_code_o(dma_code_o));
  lbis_host i_lbis_host (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
    .bus(i_lbis_if.host), .go_i(go_i), .go_reg_i(go_reg_i), .go_image_i(go_image_i),
    .go_burst_i(go_burst_i), .go_write_i(go_write_i), .go_addr_i(go_addr_i),
    .go_wdata_i(go_wdata_i), .done_o(done_o), .rdata_o(rdata_o), .dma_dual_i(dma_dual_i),
    .dma_code_i(dma_code_i), .mem_ack_i(mem_ack_i), .own_bus_i(own_bus_i),
    .dma_pending_o(dma_pending_o));
  lbis_properties i_lbis_properties (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .register_select_n(i_lbis_if.register_select_n),
    .pci_window_select_n(i_lbis_if.pci_window_select_n),
    .transfer_start_n(i_lbis_if.transfer_start_n), .burst(i_lbis_if.burst),
    .addr(i_lbis_if.addr), .dma_request_n(i_lbis_if.dma_request_n),
    .dma_acknowledge_n(i_lbis_if.dma_acknowledge_n), .dual_address(i_lbis_if.dual_address),
    .dev_ta_n(i_lbis_if.dev_ta_n), .bus_request_n(i_lbis_if.bus_request_n),
    .bus_grant_n(i_lbis_if.bus_grant_n), .dev_bb_n(i_lbis_if.dev_bb_n),
    .host_bb_n(i_lbis_if.host_bb_n), .bus_grant_ack_n(i_lbis_if.bus_grant_ack_n));
  ////////////////////////////////////////////////////////////////////////
  // clock, 50 ns period
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  // catch the one-cycle access pulse; falling edge keeps clear of updates
  always @(negedge mclk_i) begin
    if (acc_valid_o === 1'b1) begin
      seen_kind = acc_kind_o;
      seen_addr = acc_addr_o;
      seen_dat = acc_wdata_o;
      seen_wr = acc_write_o;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // watchdog: whole sequence needs well under 2000 cycles
  initial begin
    #(50 * 4000);
    errors++;
    end_sim();
  end
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {own_req_i, dma_want_i, go_i, go_reg_i, go_image_i, go_burst_i, go_write_i} = '0;
    {dma_dual_i, mem_ack_i, own_bus_i} = '0;
    {acc_rdata_i, go_addr_i, go_wdata_i, dma_code_i} = '0;
    clk_en_i = 1'b1;
    sys_rst_i = 1'b1;
    seen_kind = LBIS_ACC_NONE;
    seen_addr = '0;
    seen_dat = '0;
    seen_wr = 1'b0;
    errors = 0;
    num_checks = 0;
    rows[0] = '{1'b1, 1'b0, 1'b0, 1'b0, 32'h0000_0010, 32'h1234_5678, LBIS_ACC_REG};
    rows[1] = '{1'b0, LBIS_IMAGE0, 1'b0, 1'b1, 32'h0000_0204, 32'ha5a5_0001, LBIS_ACC_IMG0};
    rows[2] = '{1'b0, LBIS_IMAGE1, 1'b0, 1'b0, 32'h8000_0008, 32'h5a5a_0002, LBIS_ACC_IMG1};
    rows[3] = '{1'b0, LBIS_IMAGE0, 1'b1, 1'b0, 32'h0000_0100, 32'hc3c3_0003, LBIS_ACC_IMG0};
    rows[4] = '{1'b0, LBIS_IMAGE1, 1'b1, 1'b1, 32'h0000_0104, 32'h3c3c_0004, LBIS_ACC_IMG1};
    repeat (3) @(negedge mclk_i);
    sys_rst_i = 1'b0;
    // reset values
    chk(dma_pending_o, 1'b0);
    chk(own_granted_o, 1'b0);
    // table of accesses, one word per beat
    foreach (rows[i]) begin
      {go_reg_i, go_image_i, go_burst_i, go_write_i} =
        {rows[i].reg_s, rows[i].img, rows[i].bst, rows[i].wr};
      go_addr_i = rows[i].adr;
      go_wdata_i = rows[i].dat;
      acc_rdata_i = rows[i].dat;
      seen_kind = LBIS_ACC_NONE;
      go_i = 1'b1;
      @(negedge mclk_i);
      go_i = 1'b0;
      for (n = 0; n < 40 && done_o !== 1'b1; n++) @(negedge mclk_i);
      chk(done_o, 1'b1);
      chk(seen_kind, rows[i].kind);
      chk(seen_addr, rows[i].adr);
      chk(seen_wr, rows[i].wr);
      chk(seen_dat, rows[i].dat);
      if (!rows[i].wr) chk(rdata_o, rows[i].dat);
      @(negedge mclk_i);
    end
    // frozen clock enable holds the request back
    clk_en_i = 1'b0;
    dma_want_i = 1'b1;
    dma_dual_i = 1'b1;
    dma_code_i = 4'ha;
    repeat (4) @(negedge mclk_i);
    chk(dma_pending_o, 1'b0);
    clk_en_i = 1'b1;
    // dual-address beat: device acks, code captured, never error or retry
    for (n = 0; n < 40 && dma_beat_o !== 1'b1; n++) @(negedge mclk_i);
    chk(dma_beat_o, 1'b1);
    chk(dma_code_o, 4'ha);
    chk({dma_error_o, dma_retry_o}, 2'b00);
    dma_want_i = 1'b0;
    repeat (6) @(negedge mclk_i);
    // single-address beat ends by the memory side ack
    dma_dual_i = 1'b0;
    dma_code_i = 4'h5;
    dma_want_i = 1'b1;
    for (n = 0; n < 40 && dma_pending_o !== 1'b1; n++) @(negedge mclk_i);
    chk(dma_pending_o, 1'b1);
    repeat (3) @(negedge mclk_i);
    mem_ack_i = 1'b1;
    for (n = 0; n < 40 && dma_beat_o !== 1'b1; n++) @(negedge mclk_i);
    chk(dma_beat_o, 1'b1);
    chk({dma_error_o, dma_retry_o}, 2'b00);
    {mem_ack_i, dma_want_i} = 2'b00;
    repeat (6) @(negedge mclk_i);
    // ownership: held off while the host keeps the bus busy
    own_bus_i = 1'b1;
    repeat (3) @(negedge mclk_i);
    own_req_i = 1'b1;
    repeat (10) @(negedge mclk_i);
    chk(own_granted_o, 1'b0);
    own_bus_i = 1'b0;
    for (n = 0; n < 40 && own_granted_o !== 1'b1; n++) @(negedge mclk_i);
    chk(own_granted_o, 1'b1);
    own_req_i = 1'b0;
    for (n = 0; n < 40 && own_granted_o !== 1'b0; n++) @(negedge mclk_i);
    chk(own_granted_o, 1'b0);
    // second reset in mid-run
    dma_want_i = 1'b1;
    repeat (4) @(negedge mclk_i);
    sys_rst_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    chk(dma_pending_o, 1'b0);
    {sys_rst_i, dma_want_i} = 2'b00;
    repeat (4) @(negedge mclk_i);
    end_sim();
  end
endmodule
